/* logic/bio_pkg.sv */
// package for the jump / increment / or-immediate execution block
// assumes a single clock, four phases per instruction cycle
package bio_pkg;
    localparam int unsigned InstrW = 14;
    localparam int unsigned DataW = 8;
    localparam int unsigned FileAddrW = 7;
    localparam int unsigned PcW = 13;
    localparam int unsigned JumpLitW = 11;
    // opcode prefixes
    localparam logic [2:0] OpJumpAbs = 3'h5;
    localparam logic [5:0] OpIncReg = 6'h0a;
    localparam logic [5:0] OpIncSkip = 6'h0f;
    localparam logic [5:0] OpOrImm = 6'h38;
    // field positions
    localparam int unsigned DestBit = 7;
    localparam int unsigned LatchLoBit = 3;
    localparam int unsigned JumpOpLo = 11;
    localparam int unsigned RegOpLo = 8;
    // reset values
    localparam logic [PcW-1:0] PcReset = 13'h0000;
    localparam logic [DataW-1:0] AccumReset = 8'h00;
    localparam logic ZeroReset = 1'b0;
    localparam logic [1:0] PhaseReset = 2'h0;

    typedef enum logic [1:0] {PhOne, PhTwo, PhThree, PhFour} bio_phase_e;

    typedef struct packed {
        logic wrEn;
        logic [FileAddrW-1:0] addr;
        logic [DataW-1:0] data;
    } bio_file_wr_s;
endpackage

/* logic/bio_core.sv */
// execution core for jump_absolute, increment_register, increment_skip_on_zero,
// or_immediate_accum; assumes an external program memory and file register array
// that answer combinationally on the same clock.
// Function
// - jump loads 11-bit literal into program counter bits 10..0
// - jump fills pc bits 12..11 from latch bits 4..3, flags unchanged
// - jump takes two cycles, second cycle does nothing
// - increment adds one to file register, target bit picks accumulator or file
// - increment wraps, sets zero flag from result, one cycle
// - register ops: decode, read, process, write across the four phases
// - increment skip: zero result inserts a no-operation cycle, else one cycle
// - or-immediate ors accumulator with 8-bit literal into accumulator
// - or-immediate takes one cycle and updates zero flag
// - or-immediate: decode, read literal, process, write accumulator per phase
module bio_core
    import bio_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [InstrW-1:0] instrWord,
    input wire logic [DataW-1:0] fileRdData,
    input wire logic [DataW-1:0] upperBranchLatch,
    output logic [PcW-1:0] progCounter,
    output logic [FileAddrW-1:0] fileRdAddr,
    output bio_file_wr_s fileWr,
    output logic [DataW-1:0] accum,
    output logic zeroFlag,
    output logic [1:0] clockPhase,
    output logic flushCycle
);
    bio_phase_e phase_q, phase_d;
    logic [InstrW-1:0] ir_q;
    logic [DataW-1:0] operand_q;
    logic [DataW-1:0] result_q;
    logic [PcW-1:0] pc_q;
    logic [DataW-1:0] accum_q;
    logic zero_q;
    logic flush_q;
    logic [FileAddrW-1:0] rdAddr_q;
    bio_file_wr_s fileWr_q;

    // one wire per phase keeps the per-phase processes short
    wire phaseOne = phase_q == PhOne;
    wire phaseTwo = phase_q == PhTwo;
    wire phaseThree = phase_q == PhThree;
    wire phaseFour = phase_q == PhFour;

    // decode from the latched instruction
    wire [2:0] jumpOp = ir_q[InstrW-1:JumpOpLo];
    wire [5:0] regOp = ir_q[InstrW-1:RegOpLo];
    wire isJump = jumpOp == OpJumpAbs;
    wire isInc = regOp == OpIncReg;
    wire isIncSkip = regOp == OpIncSkip;
    wire isOrImm = regOp == OpOrImm;
    wire isIncAny = isInc || isIncSkip;
    wire destFile = ir_q[DestBit];
    wire [DataW-1:0] litByte = ir_q[DataW-1:0];

    // operand and result selection
    wire [FileAddrW-1:0] fAddr = instrWord[FileAddrW-1:0];
    wire [DataW-1:0] operandNext = isOrImm ? litByte : fileRdData;
    wire [DataW-1:0] incSum = DataW'(operand_q + 8'h01);
    wire [DataW-1:0] orRes = accum_q | operand_q;
    wire [DataW-1:0] resultNext = isOrImm ? orRes : incSum;
    wire resZero = result_q == 8'h00;

    // program counter: the jump target replaces the plain step
    wire [PcW-1:0] jumpTarget = {upperBranchLatch[LatchLoBit+1:LatchLoBit],
        ir_q[JumpLitW-1:0]};
    wire [PcW-1:0] pcStep = PcW'(pc_q + 13'h0001);

    // write strobes; all gated by active so a discarded word changes nothing
    wire active = !flush_q;
    wire doSkip = active && isIncSkip && resZero;
    wire accWrEn = active && ((isIncAny && !destFile) || isOrImm);
    wire zeroWrEn = active && (isInc || isOrImm);
    wire fileWrEn = active && isIncAny && destFile;
    wire flushNext = active && (isJump || doSkip);
    wire pcLoad = active && isJump;
    wire [PcW-1:0] pcNext = pcLoad ? jumpTarget : pcStep;

    always_comb
    begin
        unique case (phase_q)
            PhOne: phase_d = PhTwo;
            PhTwo: phase_d = PhThree;
            PhThree: phase_d = PhFour;
            PhFour: phase_d = PhOne;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            phase_q <= bio_phase_e'(PhaseReset);
        else
            phase_q <= phase_d;
    end

    // phase one: latch the fetched word
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            ir_q <= '0;
        else if (phaseOne)
            ir_q <= instrWord;
    end

    // address leaves in phase one so it stands through phase two, when data is taken
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            rdAddr_q <= '0;
        else if (phaseOne)
            rdAddr_q <= fAddr;
    end

    // phase two: read file register or literal
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            operand_q <= AccumReset;
        else if (phaseTwo)
            operand_q <= operandNext;
    end

    // phase three: process
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            result_q <= AccumReset;
        else if (phaseThree)
            result_q <= resultNext;
    end

    // phase four: write back; a flushed cycle writes nothing
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            accum_q <= AccumReset;
        else if (phaseFour && accWrEn)
            accum_q <= result_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            zero_q <= ZeroReset;
        else if (phaseFour && zeroWrEn)
            zero_q <= resZero;
    end

    // the write strobe lasts one clock, in the phase one that follows
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            fileWr_q <= '0;
        else if (phaseFour)
        begin
            fileWr_q.wrEn <= fileWrEn;
            fileWr_q.addr <= rdAddr_q;
            fileWr_q.data <= result_q;
        end
        else
            fileWr_q.wrEn <= 1'b0;
    end

    // jump and taken skip discard the prefetched word; the fetcher watches flushCycle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            flush_q <= 1'b0;
        else if (phaseFour)
            flush_q <= flushNext;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            pc_q <= PcReset;
        else if (phaseFour)
            pc_q <= pcNext;
    end

    assign progCounter = pc_q;
    assign fileRdAddr = rdAddr_q;
    assign fileWr = fileWr_q;
    assign accum = accum_q;
    assign zeroFlag = zero_q;
    assign clockPhase = phase_q;
    assign flushCycle = flush_q;

    // all checks sample at the rising edge and rest while reset is low
    AST_JUMP_PC: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && pcLoad |=> pc_q == $past(jumpTarget))
        else $error("jump target not loaded");

    AST_JUMP_FLAGS: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && isJump |=> $stable(zero_q) && $stable(accum_q))
        else $error("jump changed state");

    AST_JUMP_FLUSH: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && pcLoad |=> flush_q [*4])
        else $error("jump second cycle missing");

    AST_JUMP_NO_WRITE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && isJump |=> !fileWr_q.wrEn)
        else $error("jump wrote a file register");

    AST_PC_HOLD: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !phaseFour |=> $stable(pc_q))
        else $error("program counter moved outside phase four");

    AST_INC_ACC: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isInc && !destFile
        |=> accum_q == $past(result_q) && !fileWr_q.wrEn)
        else $error("increment to accumulator wrong");

    AST_INC_FILE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isInc && destFile
        |=> fileWr_q.wrEn && fileWr_q.addr == $past(rdAddr_q)
            && fileWr_q.data == $past(result_q) && $stable(accum_q))
        else $error("increment to file register wrong");

    AST_WR_PULSE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        fileWr_q.wrEn |=> !fileWr_q.wrEn)
        else $error("file write strobe longer than one clock");

    AST_INC_ZERO: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isInc |=> zero_q == ($past(result_q) == 8'h00))
        else $error("increment zero flag wrong");

    AST_INC_WRAP: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseThree && isIncAny && operand_q == 8'hff |=> result_q == 8'h00)
        else $error("increment did not wrap");

    AST_INC_ONE_CYCLE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isInc |=> !flush_q)
        else $error("increment took a second cycle");

    AST_PHASE_ORDER: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour)
        else $error("phase order broken");

    AST_OPERAND_FILE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseTwo && !isOrImm |=> operand_q == $past(fileRdData))
        else $error("file register not read in phase two");

    AST_WRITE_PHASE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !phaseFour |=> $stable(accum_q) && $stable(zero_q))
        else $error("destination written outside phase four");

    AST_SKIP_FLAGS: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && isIncSkip |=> $stable(zero_q))
        else $error("skip changed zero flag");

    AST_SKIP_DEST: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isIncSkip && destFile
        |=> fileWr_q.wrEn && fileWr_q.data == $past(result_q))
        else $error("skip to file register wrong");

    AST_SKIP_ACC: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isIncSkip && !destFile
        |=> accum_q == $past(result_q) && !fileWr_q.wrEn)
        else $error("skip to accumulator wrong");

    AST_SKIP_TAKEN: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isIncSkip |=> flush_q == $past(resZero))
        else $error("skip decision wrong");

    AST_PC_STEP: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && !pcLoad |=> pc_q == $past(pc_q) + 13'h0001)
        else $error("program counter did not step");

    AST_OR_RESULT: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isOrImm
        |=> accum_q == $past(result_q) && zero_q == ($past(result_q) == 8'h00))
        else $error("or immediate result wrong");

    AST_OR_ONE_CYCLE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && active && isOrImm |=> !flush_q)
        else $error("or immediate took a second cycle");

    AST_OR_LITERAL: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseTwo && isOrImm |=> operand_q == $past(ir_q[DataW-1:0]))
        else $error("literal not read");

    AST_OR_NO_FILE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && isOrImm |=> !fileWr_q.wrEn)
        else $error("or immediate wrote a file register");

    AST_FLUSH_QUIET: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        phaseFour && flush_q
        |=> $stable(accum_q) && $stable(zero_q) && !fileWr_q.wrEn && !flush_q)
        else $error("flushed cycle changed state");
endmodule

/* testbench/branch_increment_or_exec_test.sv */
// self-checking bench for bio_core, no partner model
// assumes one word taken per four clocks, phase one first after reset
module branch_increment_or_exec_test
    import bio_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [InstrW-1:0] instrWord = '0;
    logic [DataW-1:0] fileRdData = '0;
    logic [DataW-1:0] upperBranchLatch = '0;
    logic [PcW-1:0] progCounter;
    logic [FileAddrW-1:0] fileRdAddr;
    bio_file_wr_s fileWr;
    logic [DataW-1:0] accum;
    logic zeroFlag;
    logic [1:0] clockPhase;
    logic flushCycle;
    logic [PcW-1:0] pcPrev;
    int fail_count = 0;
    int cmp_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    bio_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .instrWord(instrWord),
        .fileRdData(fileRdData), .upperBranchLatch(upperBranchLatch),
        .progCounter(progCounter), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
        .accum(accum), .zeroFlag(zeroFlag), .clockPhase(clockPhase),
        .flushCycle(flushCycle));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // file data is held for the whole cycle since the core reads it mid-cycle
    task automatic exec(input logic [InstrW-1:0] word, input logic [DataW-1:0] fdata);
        int n;
        for (n = 0; n < 8 && clockPhase !== 2'h0; n++)
            @(negedge clk_sys);
        if (n == 8)
        begin
            fail_count++;
            close_out();
        end
        pcPrev = progCounter;
        instrWord = word;
        fileRdData = fdata;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic test_or();
        exec({OpOrImm, 8'h00}, 8'h00);
        check(zeroFlag, 1'b1);
        check(progCounter, pcPrev + 13'h1);
        check(clockPhase, 2'h0);
        @(negedge clk_sys);
        check(clockPhase, 2'h1);
        exec({OpOrImm, 8'h9a}, 8'h00);
        exec({OpOrImm, 8'h35}, 8'h00);
        check(accum, 8'hbf);
        check(zeroFlag, 1'b0);
        $display("test_or done");
    endtask

    task automatic test_inc();
        exec({OpIncReg, 1'b0, 7'h7f}, 8'hff);
        check(accum, 8'h00);
        check(zeroFlag, 1'b1);
        check(fileRdAddr, 7'h7f);
        check(fileWr.wrEn, 1'b0);
        exec({OpIncReg, 1'b1, 7'h05}, 8'h41);
        check(fileWr, {1'b1, 7'h05, 8'h42});
        check(zeroFlag, 1'b0);
        check(accum, 8'h00);
        $display("test_inc done");
    endtask

    task automatic test_skip();
        exec({OpOrImm, 8'h00}, 8'h00);
        exec({OpIncSkip, 1'b1, 7'h10}, 8'h10);
        check(fileWr, {1'b1, 7'h10, 8'h11});
        check(zeroFlag, 1'b1);
        check(flushCycle, 1'b0);
        exec({OpOrImm, 8'h01}, 8'h00);
        exec({OpIncSkip, 1'b0, 7'h11}, 8'hff);
        check(accum, 8'h00);
        check(zeroFlag, 1'b0);
        check(flushCycle, 1'b1);
        exec({OpOrImm, 8'h80}, 8'h00);
        check(accum, 8'h00);
        check(flushCycle, 1'b0);
        $display("test_skip done");
    endtask

    task automatic test_jump();
        exec({OpOrImm, 8'h00}, 8'h00);
        upperBranchLatch = 8'h5a;
        exec({OpJumpAbs, 11'h2a5}, 8'h00);
        check(progCounter, 13'h1aa5);
        check(zeroFlag, 1'b1);
        check(flushCycle, 1'b1);
        exec({OpIncReg, 1'b1, 7'h01}, 8'h7f);
        check(fileWr.wrEn, 1'b0);
        check(zeroFlag, 1'b1);
        check(progCounter, 13'h1aa6);
        check(flushCycle, 1'b0);
        $display("test_jump done");
    endtask

    initial
    begin
        repeat (6) @(negedge clk_sys);
        check(progCounter, PcReset);
        reset_n = 1'b1;
        test_or();
        test_inc();
        test_skip();
        test_jump();
        close_out();
    end
endmodule
